// ==== srdr_initiator.sv ====
// Initiator end: sends a command block, the re-assign list, and collects data-in and status.
// Assumes the user presents defect bytes in ascending address order.
`timescale 1ns/1ps

module srdr_initiator (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Link to the target
  srdr_link_if.initiator   link,
  // Command request
  input  wire logic [2:0]  my_id_in,
  input  wire logic        req_valid_in,
  input  wire logic [47:0] req_cdb_in,
  input  wire logic [15:0] dl_len_in,
  output logic             req_ready_out,
  // Defect list bytes
  input  wire logic        dl_valid_in,
  input  wire logic [7:0]  dl_data_in,
  output logic             dl_ready_out,
  // Results
  output logic             rx_valid_out,
  output logic [7:0]       rx_data_out,
  output logic             done_out,
  output logic [7:0]       status_out,
  output logic             irq_out,
  output logic             ctx_lost_out
);

  srdr_pkg::srdr_ini_s r;
  srdr_pkg::srdr_ini_s next_r;

  logic [5:0][7:0] cdb_in;
  logic [7:0]      hdr_byte;
  logic            is_rsn;

  assign cdb_in = req_cdb_in;
  assign is_rsn = (r.cdb[0] == `SRDR_OP_REASSIGN);
  assign hdr_byte = (r.cnt == 16'h2) ? r.len[15:8] : (r.cnt == 16'h3) ? r.len[7:0] : 8'h00;

  always_comb begin
    next_r      = r;
    next_r.rx_v = 1'b0;
    next_r.done = 1'b0;
    next_r.irq  = 1'b0;
    next_r.lost = 1'b0;
    unique case (r.st)
      srdr_pkg::INI_IDLE: begin
        if (req_valid_in) begin
          next_r.cdb  = cdb_in;
          // Reserved fields are forced to zero per opcode so the target never refuses them.
          next_r.cdb[5][7:2] = 6'h00;
          if (cdb_in[0] == `SRDR_OP_REASSIGN) begin
            next_r.cdb[1][4:0] = 5'h00;
            next_r.cdb[2]      = 8'h00;
            next_r.cdb[3]      = 8'h00;
            next_r.cdb[4]      = 8'h00;
          end else if (cdb_in[0] == `SRDR_OP_RECV_DIAG) begin
            next_r.cdb[1][4:0] = 5'h00;
            next_r.cdb[2]      = 8'h00;
          end else if (cdb_in[0] == `SRDR_OP_RELEASE) begin
            next_r.cdb[1][7:5] = 3'h0;
            next_r.cdb[1][0]   = 1'b0;
            next_r.cdb[3]      = 8'h00;
            next_r.cdb[4]      = 8'h00;
          end
          next_r.len  = dl_len_in;
          next_r.cidx = 3'h0;
          next_r.cnt  = 16'h0;
          next_r.st   = srdr_pkg::INI_CDB;
        end
      end
      srdr_pkg::INI_CDB: begin
        if (link.h2d_ready) begin
          next_r.cidx = r.cidx + 3'h1;
          if (r.cidx == `SRDR_CDB_LAST) begin
            next_r.st = is_rsn ? srdr_pkg::INI_DOUT : srdr_pkg::INI_WAIT;
          end
        end
      end
      srdr_pkg::INI_DOUT: begin
        if (link.h2d_ready && (r.cnt <= `SRDR_HDR_LAST || dl_valid_in)) begin
          next_r.cnt = r.cnt + 16'h1;
          if (r.cnt == r.len + `SRDR_HDR_LAST) begin
            next_r.st = srdr_pkg::INI_WAIT;
          end
        end
      end
      srdr_pkg::INI_WAIT: begin
        if (link.d2h_valid) begin
          next_r.rx_v = 1'b1;
          next_r.rx_d = link.d2h_data;
        end
        if (link.sts_valid) begin
          next_r.done   = 1'b1;
          next_r.status = link.sts_code;
          next_r.irq    = link.sts_irq;
          next_r.st     = srdr_pkg::INI_IDLE;
        end
      end
    endcase
    if (link.ctl_reset) begin
      next_r.st   = srdr_pkg::INI_IDLE;
      next_r.lost = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r    <= '0;
      r.st <= srdr_pkg::INI_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign link.init_id   = my_id_in;
  assign link.h2d_valid = (r.st == srdr_pkg::INI_CDB) ||
                          ((r.st == srdr_pkg::INI_DOUT) && (r.cnt <= `SRDR_HDR_LAST || dl_valid_in));
  assign link.h2d_data  = (r.st == srdr_pkg::INI_CDB) ? r.cdb[r.cidx] :
                          (r.cnt <= `SRDR_HDR_LAST) ? hdr_byte : dl_data_in;
  assign link.d2h_ready = (r.st == srdr_pkg::INI_WAIT);
  assign dl_ready_out   = (r.st == srdr_pkg::INI_DOUT) && (r.cnt > `SRDR_HDR_LAST) && link.h2d_ready;
  assign req_ready_out  = (r.st == srdr_pkg::INI_IDLE);
  assign rx_valid_out   = r.rx_v;
  assign rx_data_out    = r.rx_d;
  assign done_out       = r.done;
  assign status_out     = r.status;
  assign irq_out        = r.irq;
  assign ctx_lost_out   = r.lost;

endmodule

// ==== srdr_link_checker.sv ====
// Assertions on the command link between the initiator and target ends.
// Assumes one clock for both ends and signals taken straight from the link interface.
`timescale 1ns/1ps

module srdr_link_checker (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  // Link signals
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready,
  input wire logic       sts_valid,
  input wire logic [7:0] sts_code,
  input wire logic       sts_irq,
  input wire logic       ctl_reset
);
  // Command bytes are tracked here so that each status can be tied to the block that caused it.
  logic [3:0]  hcnt;
  logic [7:0]  op;
  logic [15:0] alloc;
  logic [1:0]  lf;
  logic        cdb_end;
  logic [15:0] dcnt;
  wire         take = h2d_valid && h2d_ready;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hcnt <= 4'h0;
      op <= 8'h00;
      alloc <= 16'h0000;
      lf <= 2'h0;
      cdb_end <= 1'b0;
      dcnt <= 16'h0000;
    end else begin
      cdb_end <= take && hcnt == 4'h5;
      hcnt <= (sts_valid || ctl_reset) ? 4'h0 : hcnt + {3'h0, take && hcnt < 4'h7};
      dcnt <= sts_valid ? 16'h0000 : dcnt + {15'h0, d2h_valid && d2h_ready};
      if (take && hcnt == 4'h0) op <= h2d_data;
      if (take && hcnt == 4'h3) alloc[15:8] <= h2d_data;
      if (take && hcnt == 4'h4) alloc[7:0] <= h2d_data;
      if (take && hcnt == 4'h5) lf <= h2d_data[1:0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_cdb_end(logic [7:0] code);
    cdb_end && op == code;
  endsequence
  sequence s_d2h_take;
    d2h_valid && d2h_ready;
  endsequence

  property p_irq; sts_irq |-> sts_valid && sts_code == 8'h10 && lf == 2'h3; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without flag and link");
  property p_link; sts_valid && sts_code != 8'h02 |-> sts_code == (lf[0] ? 8'h10 : 8'h00); endproperty
  a_link: assert property (p_link) else $error("good status code disagrees with link bit");
  property p_sts_pulse; sts_valid |=> !sts_valid; endproperty
  a_sts_pulse: assert property (p_sts_pulse) else $error("status held longer than one cycle");
  property p_rel; s_cdb_end(8'h17) |-> !h2d_ready ##1 sts_valid; endproperty
  a_rel: assert property (p_rel) else $error("release status not immediate");
  property p_reassign; s_cdb_end(8'h07) |-> !h2d_ready ##1 h2d_ready; endproperty
  a_reassign: assert property (p_reassign) else $error("defect list not taken after command");
  property p_zero; s_cdb_end(8'h1C) ##0 alloc == 16'h0000 |-> !d2h_valid [*3]; endproperty
  a_zero: assert property (p_zero) else $error("data sent with zero allocation");
  property p_alloc; d2h_valid |-> op == 8'h1C && dcnt < alloc; endproperty
  a_alloc: assert property (p_alloc) else $error("data beyond allocation");
  property p_din_end; s_d2h_take |=> d2h_valid || sts_valid; endproperty
  a_din_end: assert property (p_din_end) else $error("data-in phase stalled");
  property p_rst; ctl_reset |=> !ctl_reset && h2d_ready; endproperty
  a_rst: assert property (p_rst) else $error("controller reset not a clean pulse");
endmodule

// ==== srdr_link_if.sv ====
// Command link between the initiator end and the target end.
// Assumes one clock shared by both ends; byte paths use valid and ready.
`timescale 1ns/1ps

interface srdr_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_ready;
  logic [2:0] init_id;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_ready;
  logic       sts_valid;
  logic [7:0] sts_code;
  logic       sts_irq;
  logic       disc;
  logic       ctl_reset;

  modport target (input h2d_valid, h2d_data, init_id, d2h_ready,
                  output h2d_ready, d2h_valid, d2h_data, sts_valid, sts_code, sts_irq, disc, ctl_reset);
  modport initiator (output h2d_valid, h2d_data, init_id, d2h_ready,
                     input h2d_ready, d2h_valid, d2h_data, sts_valid, sts_code, sts_irq, disc, ctl_reset);
endinterface

// ==== srdr_pkg.sv ====
// Types shared by both ends of the command link.
// Assumes the constants header is on the include path.
`include "srdr_regs.svh"

package srdr_pkg;

  typedef enum logic [6:0] {
    TGT_CDB  = 7'h01,
    TGT_EXEC = 7'h02,
    TGT_HDR  = 7'h04,
    TGT_DESC = 7'h08,
    TGT_CHK  = 7'h10,
    TGT_DIN  = 7'h20,
    TGT_STS  = 7'h40
  } srdr_tgt_e;

  typedef enum logic [3:0] {
    INI_IDLE = 4'h1,
    INI_CDB  = 4'h2,
    INI_DOUT = 4'h4,
    INI_WAIT = 4'h8
  } srdr_ini_e;

  typedef struct packed {
    srdr_tgt_e                          st;
    logic [5:0][7:0]                    cdb;
    logic [2:0]                         cidx;
    logic [2:0]                         ini;
    logic [15:0]                        cnt;
    logic [15:0]                        len;
    logic [31:0]                        lba;
    logic [`SRDR_BSF_DEPTH-1:0][31:0]   bad_sector_file;
    logic [`SRDR_BSF_DEPTH-1:0]         bsf_v;
    logic [31:0]                        last_ok;
    logic                               full_err;
    logic [7:0]                         sd_seen;
    logic [`SRDR_UNITS-1:0]             res_v;
    logic [`SRDR_UNITS-1:0][2:0]        res_own;
    logic [`SRDR_UNITS-1:0]             res_tp;
    logic [`SRDR_UNITS-1:0][2:0]        res_tpid;
    logic [`SRDR_UNITS-1:0][7:0]        res_id;
    logic [7:0]                         sts;
    logic                               irq;
    logic [3:0]                         key;
    logic [31:0]                        info;
    logic                               dvalid;
    logic [7:0]                         ddata;
    logic                               ctl_rst;
    logic                               dfct;
    logic [26:0]                        track;
    logic [4:0]                         blk;
  } srdr_tgt_s;

  typedef struct packed {
    srdr_ini_e        st;
    logic [5:0][7:0]  cdb;
    logic [2:0]       cidx;
    logic [15:0]      cnt;
    logic [15:0]      len;
    logic             rx_v;
    logic [7:0]       rx_d;
    logic             done;
    logic [7:0]       status;
    logic             irq;
    logic             lost;
  } srdr_ini_s;

endpackage

// ==== srdr_regs.svh ====
// Constants for the re-assign, diagnostic-results and release command handler.
// Assumes inclusion by bare name from the package; the two ends use its macros without including it.
`ifndef SRDR_REGS_SVH
`define SRDR_REGS_SVH

`define SRDR_OP_REASSIGN   8'h07
`define SRDR_OP_RELEASE    8'h17
`define SRDR_OP_RECV_DIAG  8'h1C
`define SRDR_OP_SEND_DIAG  8'h1D
`define SRDR_STS_GOOD      8'h00
`define SRDR_STS_CHECK     8'h02
`define SRDR_STS_INTER     8'h10
`define SRDR_KEY_NONE      4'h0
`define SRDR_KEY_MEDIUM    4'h3
`define SRDR_KEY_ILLEGAL   4'h5
`define SRDR_CDB_LAST      3'h5
`define SRDR_HDR_LAST      16'h0003
`define SRDR_BIT_LINK      0
`define SRDR_BIT_FLAG      1
`define SRDR_BIT_THIRD_PARTY_RELEASE_BIT      4
`define SRDR_LUN_HI        7
`define SRDR_LUN_LO        5
`define SRDR_TPID_HI       3
`define SRDR_TPID_LO       1
`define SRDR_BSF_DEPTH     8
`define SRDR_UNITS         8
`define SRDR_SPT_LOG2      5

`endif

// ==== srdr_target.sv ====
// Target end: takes command blocks and data-out bytes from the link, returns data-in and status.
// Assumes the initiator keeps its own duties and sends six command bytes before any data.
`timescale 1ns/1ps

module srdr_target (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Link to the initiator
  srdr_link_if.target      link,
  // Controller control
  input  wire logic        selftest_in,
  input  wire logic        disc_en_in,
  input  wire logic        lun_busy_in,
  output logic [2:0]       lun_out,
  // Diagnostic result source
  input  wire logic [15:0] diag_len_in,
  input  wire logic [7:0]  diag_byte_in,
  output logic [15:0]      diag_idx_out,
  // Reservation loading
  input  wire logic        res_set_in,
  input  wire logic [2:0]  res_lun_in,
  input  wire logic [2:0]  res_owner_in,
  input  wire logic        res_tp_in,
  input  wire logic [2:0]  res_tpid_in,
  input  wire logic [7:0]  res_id_in,
  output logic [7:0]       res_held_out,
  // Sense and defect report
  output logic [3:0]       sense_key_out,
  output logic [31:0]      sense_info_out,
  output logic             defect_valid_out,
  output logic [26:0]      defect_track_out,
  output logic [4:0]       defect_block_out
);

  srdr_pkg::srdr_tgt_s r;
  srdr_pkg::srdr_tgt_s next_r;

  logic [`SRDR_BSF_DEPTH-1:0] hit;
  logic [`SRDR_UNITS-1:0]     rel;
  logic [7:0]                 op;
  logic [7:0]                 b1;
  logic                       link_bit;
  logic                       flag_bit;
  logic [15:0]                alloc;
  logic [15:0]                lim;

  assign op       = r.cdb[0];
  assign b1       = r.cdb[1];
  assign link_bit = r.cdb[5][`SRDR_BIT_LINK];
  assign flag_bit = r.cdb[5][`SRDR_BIT_FLAG];
  assign alloc    = {r.cdb[3], r.cdb[4]};
  assign lim      = (alloc < diag_len_in) ? alloc : diag_len_in;

  genvar g;
  generate
    for (g = 0; g < `SRDR_BSF_DEPTH; g++) begin : g_bsf
      assign hit[g] = r.bsf_v[g] && (r.bad_sector_file[g] == r.lba);
    end
    for (g = 0; g < `SRDR_UNITS; g++) begin : g_res
      // The third-party ID is only compared while the third-party bit is set.
      assign rel[g] = r.res_v[g] && (r.res_own[g] == r.ini) && (r.res_id[g] == r.cdb[2])
                      && (b1[`SRDR_BIT_THIRD_PARTY_RELEASE_BIT] ? (r.res_tp[g] && (r.res_tpid[g] == b1[`SRDR_TPID_HI:`SRDR_TPID_LO]))
                                             : !r.res_tp[g]);
    end
  endgenerate

  always_comb begin
    logic       free_ok;
    logic [2:0] free_ix;
    logic       fin;
    next_r         = r;
    free_ok        = 1'b0;
    free_ix        = 3'h0;
    fin            = 1'b0;
    next_r.ctl_rst = 1'b0;
    next_r.dfct    = 1'b0;
    for (int i = `SRDR_BSF_DEPTH - 1; i >= 0; i--) begin
      if (!r.bsf_v[i]) begin
        free_ok = 1'b1;
        free_ix = 3'(i);
      end
    end
    unique case (r.st)
      srdr_pkg::TGT_CDB: begin
        if (link.h2d_valid) begin
          next_r.cdb[r.cidx] = link.h2d_data;
          if (r.cidx == 3'h0) begin
            next_r.ini = link.init_id;
          end
          next_r.cidx = r.cidx + 3'h1;
          if (r.cidx == `SRDR_CDB_LAST) begin
            next_r.cidx = 3'h0;
            next_r.st   = srdr_pkg::TGT_EXEC;
          end
        end
      end
      srdr_pkg::TGT_EXEC: begin
        next_r.sts  = `SRDR_STS_GOOD;
        next_r.key  = `SRDR_KEY_NONE;
        next_r.info = 32'h0;
        next_r.cnt  = 16'h0;
        next_r.len  = 16'h0;
        next_r.st   = srdr_pkg::TGT_STS;
        if (op == `SRDR_OP_REASSIGN) begin
          if ((|b1[4:0]) || (|r.cdb[2]) || (|r.cdb[3]) || (|r.cdb[4]) || (|r.cdb[5][7:2])) begin
            next_r.sts = `SRDR_STS_CHECK;
            next_r.key = `SRDR_KEY_ILLEGAL;
          end else begin
            next_r.full_err = 1'b0;
            next_r.st       = srdr_pkg::TGT_HDR;
          end
        end else if (op == `SRDR_OP_RECV_DIAG) begin
          if ((|b1[4:0]) || (|r.cdb[2]) || (|r.cdb[5][7:2])) begin
            next_r.sts = `SRDR_STS_CHECK;
            next_r.key = `SRDR_KEY_ILLEGAL;
          end else if (!r.sd_seen[r.ini]) begin
            next_r.sts = `SRDR_STS_CHECK;
            next_r.key = `SRDR_KEY_ILLEGAL;
          end else begin
            next_r.len = lim;
            next_r.st  = srdr_pkg::TGT_DIN;
          end
        end else if (op == `SRDR_OP_RELEASE) begin
          if ((|b1[7:5]) || b1[0] || (|r.cdb[3]) || (|r.cdb[4]) || (|r.cdb[5][7:2])) begin
            next_r.sts = `SRDR_STS_CHECK;
            next_r.key = `SRDR_KEY_ILLEGAL;
          end else begin
            // No match leaves everything as is and still answers good.
            next_r.res_v = r.res_v & ~rel;
          end
        end else if (op == `SRDR_OP_SEND_DIAG) begin
          next_r.sd_seen[r.ini] = 1'b1;
        end else begin
          next_r.sts = `SRDR_STS_CHECK;
          next_r.key = `SRDR_KEY_ILLEGAL;
        end
      end
      srdr_pkg::TGT_HDR: begin
        if (link.h2d_valid) begin
          if (r.cnt == 16'h0002) begin
            next_r.len[15:8] = link.h2d_data;
          end
          if (r.cnt == `SRDR_HDR_LAST) begin
            next_r.len[7:0] = link.h2d_data;
            next_r.cnt      = 16'h0;
            if ({r.len[15:8], link.h2d_data} == 16'h0) begin
              fin = 1'b1;
            end else begin
              next_r.st = srdr_pkg::TGT_DESC;
            end
          end else begin
            next_r.cnt = r.cnt + 16'h1;
          end
        end
      end
      srdr_pkg::TGT_DESC: begin
        if (link.h2d_valid) begin
          next_r.lba = {r.lba[23:0], link.h2d_data};
          next_r.cnt = r.cnt + 16'h1;
          if (r.cnt[1:0] == 2'h3) begin
            next_r.st = srdr_pkg::TGT_CHK;
          end else if (r.cnt + 16'h1 == r.len) begin
            fin = 1'b1;
          end
        end
      end
      srdr_pkg::TGT_CHK: begin
        if (hit == '0) begin
          if (free_ok) begin
            next_r.bad_sector_file[free_ix]   = r.lba;
            next_r.bsf_v[free_ix] = 1'b1;
            next_r.last_ok        = r.lba;
            next_r.dfct           = 1'b1;
            next_r.track          = r.lba[31:`SRDR_SPT_LOG2];
            next_r.blk            = r.lba[`SRDR_SPT_LOG2-1:0];
          end else begin
            // The rest of the list is still drained so the link stays in step.
            next_r.full_err = 1'b1;
          end
        end
        if (r.cnt >= r.len) begin
          fin = 1'b1;
        end else begin
          next_r.st = srdr_pkg::TGT_DESC;
        end
      end
      srdr_pkg::TGT_DIN: begin
        if (!r.dvalid || link.d2h_ready) begin
          next_r.dvalid = 1'b0;
          if (r.cnt < r.len) begin
            next_r.dvalid = 1'b1;
            next_r.ddata  = diag_byte_in;
            next_r.cnt    = r.cnt + 16'h1;
          end else if (!r.dvalid || link.d2h_ready) begin
            next_r.st = srdr_pkg::TGT_STS;
          end
        end
      end
      srdr_pkg::TGT_STS: begin
        // The interrupt request lives only as long as its status byte.
        next_r.irq = 1'b0;
        next_r.st  = srdr_pkg::TGT_CDB;
      end
    endcase
    if (fin) begin
      next_r.st = srdr_pkg::TGT_STS;
      if (next_r.full_err) begin
        next_r.sts  = `SRDR_STS_CHECK;
        next_r.key  = `SRDR_KEY_MEDIUM;
        next_r.info = r.last_ok;
      end
    end
    if (r.st == srdr_pkg::TGT_EXEC || fin || r.st == srdr_pkg::TGT_DIN) begin
      if (next_r.st == srdr_pkg::TGT_STS) begin
        next_r.irq = 1'b0;
        if (next_r.sts == `SRDR_STS_GOOD && link_bit) begin
          next_r.sts = `SRDR_STS_INTER;
          next_r.irq = flag_bit;
        end
      end
    end
    if (res_set_in) begin
      next_r.res_v[res_lun_in]    = 1'b1;
      next_r.res_own[res_lun_in]  = res_owner_in;
      next_r.res_tp[res_lun_in]   = res_tp_in;
      next_r.res_tpid[res_lun_in] = res_tpid_in;
      next_r.res_id[res_lun_in]   = res_id_in;
    end
    if (selftest_in) begin
      // Self-test wipes every piece of context, the defect file included.
      next_r         = '0;
      next_r.st      = srdr_pkg::TGT_CDB;
      next_r.ctl_rst = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r    <= '0;
      r.st <= srdr_pkg::TGT_CDB;
    end else begin
      r <= next_r;
    end
  end

  assign link.h2d_ready = (r.st == srdr_pkg::TGT_CDB) || (r.st == srdr_pkg::TGT_HDR) || (r.st == srdr_pkg::TGT_DESC);
  assign link.d2h_valid = r.dvalid;
  assign link.d2h_data  = r.ddata;
  assign link.sts_valid = (r.st == srdr_pkg::TGT_STS);
  assign link.sts_code  = r.sts;
  assign link.sts_irq   = r.irq;
  assign link.ctl_reset = r.ctl_rst;
  assign link.disc      = disc_en_in && lun_busy_in && (r.st != srdr_pkg::TGT_CDB);

  assign lun_out          = b1[`SRDR_LUN_HI:`SRDR_LUN_LO];
  assign diag_idx_out     = r.cnt;
  assign res_held_out     = r.res_v;
  assign sense_key_out    = r.key;
  assign sense_info_out   = r.info;
  assign defect_valid_out = r.dfct;
  assign defect_track_out = r.track;
  assign defect_block_out = r.blk;

endmodule

// ==== testbench.sv ====
// Self-checking bench: initiator and target ends joined by the link, user sides driven here.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/1ps

module testbench;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [2:0]  my_id_in = 3'h2;
  logic        req_valid_in = 1'b0;
  logic [47:0] req_cdb_in = 48'h0;
  logic [15:0] dl_len_in = 16'h0;
  logic        dl_valid_in = 1'b0;
  logic [7:0]  dl_data_in = 8'h00;
  logic        req_ready_out, dl_ready_out, rx_valid_out, done_out, irq_out, ctx_lost_out;
  logic [7:0]  rx_data_out, status_out, diag_byte_in, res_held_out, res_id_in = 8'h00;
  logic        selftest_in = 1'b0, disc_en_in = 1'b1, lun_busy_in = 1'b0, res_set_in = 1'b0, res_tp_in = 1'b0;
  logic [2:0]  lun_out, res_lun_in = 3'h0, res_owner_in = 3'h0, res_tpid_in = 3'h0;
  logic [15:0] diag_len_in = 16'h0, diag_idx_out;
  logic [3:0]  sense_key_out;
  logic [31:0] sense_info_out, lfsr_v = 32'hAF2472F4, fq[$], bad_sector_file[$];
  logic        defect_valid_out, dsc, lost, irq_s;
  logic [26:0] defect_track_out;
  logic [4:0]  defect_block_out;
  logic [7:0]  rq[$], dq[$];
  int          miscompares = 0, checks_done = 0, cyc = 0;

  always #4 clk_in = ~clk_in;
  // Diagnostic data must follow the index at once, so it is a function of the index, not a clocked drive.
  assign diag_byte_in = diag_idx_out[7:0] ^ 8'hA5;

  srdr_link_if link();
  srdr_initiator srdr_initiator_i (.*);
  srdr_target srdr_target_i (.*);
  srdr_link_checker srdr_link_checker_i (.clk_in(clk_in), .resetn_in(resetn_in), .h2d_valid(link.h2d_valid),
    .h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready),
    .sts_valid(link.sts_valid), .sts_code(link.sts_code), .sts_irq(link.sts_irq), .ctl_reset(link.ctl_reset));

  function automatic logic [31:0] rnd();
    lfsr_v = {lfsr_v[30:0], lfsr_v[31] ^ lfsr_v[21] ^ lfsr_v[1] ^ lfsr_v[0]};
    return lfsr_v;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Results, defect reports and descriptor bytes are handled here so each command task stays short.
  always @(posedge clk_in) begin
    cyc++;
    if (rx_valid_out) rq.push_back(rx_data_out);
    if (defect_valid_out) fq.push_back({defect_track_out, defect_block_out});
    if (link.disc) dsc = 1'b1;
    if (ctx_lost_out) lost = 1'b1;
    if (dl_valid_in && dl_ready_out) void'(dq.pop_front());
    dl_valid_in <= dq.size() != 0;
    dl_data_in <= dq.size() != 0 ? dq[0] : 8'h00;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic cmd(input logic [7:0] op, b1, b2, b3, b4, b5, est);
    int t;
    rq = {};
    dsc = 1'b0;
    t = 0;
    req_cdb_in <= {b5, b4, b3, b2, b1, op};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    while (!req_ready_out) @(posedge clk_in);
    req_valid_in <= 1'b0;
    while (done_out !== 1'b1 && t < 2000) begin
      @(posedge clk_in);
      t++;
    end
    if (done_out !== 1'b1) miscompares++;
    irq_s = irq_out;
    chk(status_out, est);
  endtask

  task automatic rs(input logic [2:0] u, o, input logic tp, input logic [2:0] ti, input logic [7:0] id);
    {res_lun_in, res_owner_in, res_tp_in, res_tpid_in, res_id_in} <= {u, o, tp, ti, id};
    res_set_in <= 1'b1;
    @(posedge clk_in);
    res_set_in <= 1'b0;
  endtask

  // The model keeps its own defect file and decides what is stored, skipped or refused.
  task automatic ra(input logic [31:0] al[$]);
    logic [31:0] ex[$];
    logic [31:0] last;
    logic        err;
    err = 1'b0;
    last = 32'h0;
    fq = {};
    foreach (al[i]) begin
      for (int b = 3; b >= 0; b--) dq.push_back(al[i][8*b+:8]);
      if (al[i] inside {bad_sector_file}) continue;
      if (bad_sector_file.size() < 8) begin
        bad_sector_file.push_back(al[i]);
        ex.push_back(al[i]);
        last = al[i];
      end else err = 1'b1;
    end
    dl_len_in <= 16'(4 * al.size());
    cmd(8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, err ? 8'h02 : 8'h00);
    chk(sense_key_out, err ? 4'h3 : 4'h0);
    chk(sense_info_out, err ? last : 32'h0);
    chk(fq.size(), ex.size());
    foreach (ex[i]) chk(fq[i], ex[i]);
  endtask

  initial begin
    logic [31:0] a, aq[$];
    logic [15:0] len, av;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rs(3'h3, 3'h2, 1'b0, 3'h0, 8'h44);
    my_id_in <= 3'h5;
    cmd(8'h17, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(res_held_out, 8'h08);
    my_id_in <= 3'h2;
    cmd(8'h17, 8'h00, 8'h43, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(res_held_out, 8'h08);
    cmd(8'h17, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(res_held_out, 8'h00);
    cmd(8'h17, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00);
    rs(3'h5, 3'h2, 1'b1, 3'h3, 8'h11);
    cmd(8'h17, 8'h14, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(res_held_out, 8'h20);
    cmd(8'h17, 8'h16, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(res_held_out, 8'h00);
    // The initiator end clears reserved bytes itself, so this block is accepted.
    cmd(8'h17, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
    chk(sense_key_out, 4'h0);
    cmd(8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
    chk(sense_key_out, 4'h5);
    $display("release tests done");
    cmd(8'h1C, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02);
    chk(sense_key_out, 4'h5);
    cmd(8'h1D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    // Release has no unit field, so the unit and link tests use diagnostic results with no data.
    for (int i = 0; i < 4; i++) begin
      cmd(8'h1C, 8'((2 * i + 1) << 5), 8'h00, 8'h00, 8'h00, 8'(i), i[0] ? 8'h10 : 8'h00);
      chk(irq_s, i == 3);
      chk(lun_out, 2 * i + 1);
    end
    len = 16'(4 + rnd() % 8);
    diag_len_in <= len;
    for (int i = 0; i < 3; i++) begin
      av = i == 0 ? 16'h0 : i == 1 ? 16'(1 + rnd() % 3) : len + 16'h5;
      lun_busy_in <= (i != 0);
      disc_en_in <= i[0];
      cmd(8'h1C, 8'h00, 8'h00, av[15:8], av[7:0], 8'h00, 8'h00);
      chk(rq.size(), av < len ? av : len);
      foreach (rq[j]) chk(rq[j], 8'(j) ^ 8'hA5);
      chk(dsc, i[0]);
    end
    my_id_in <= 3'h6;
    cmd(8'h1C, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02);
    my_id_in <= 3'h2;
    $display("diagnostic tests done");
    a = rnd() & 32'h00FFFFFF;
    aq = {a, a};
    repeat (4) begin
      a = a + (rnd() & 32'hFF) + 32'h1;
      aq.push_back(a);
    end
    ra(aq);
    aq = {a};
    repeat (5) begin
      a = a + (rnd() & 32'hFF) + 32'h1;
      aq.push_back(a);
    end
    ra(aq);
    $display("re-assign tests done");
    rs(3'h1, 3'h2, 1'b0, 3'h0, 8'h01);
    lost = 1'b0;
    selftest_in <= 1'b1;
    @(posedge clk_in);
    selftest_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(lost, 1'b1);
    chk(res_held_out, 8'h00);
    cmd(8'h1C, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02);
    $display("self-test tests done");
    finish_test();
  end
endmodule
